// File: rtl/ascs_regs.svh
// register map, field positions, reset values and codes of the async memory cycle shaper
// Summary of operation
// - address and lanes held setup cycles before strobe
// - first access counts setup from chip select
// - strobe low exactly the programmed strobe count
// - address and lanes stable for hold count
// - second variant hold fields one bit wider
// - first variant three-bit type, ROMs space one
// - second variant four-bit type, 8/16/32 wide
// - second variant turnaround after read before write or other-space access
// - counts on this block's single cycle clock
// - separate read and write timing sets
// - field values are the real cycle counts
// - zero setup or strobe acts as one
// - zero hold ends cycle at strobe rise
// - first variant first access setup at least two
// - hold ends by address change or deselect
// - cycle starts with select low, address valid
// - output enable low through whole read
// - read data taken at strobe end edge
// - synchronous types ignore async timing fields
`ifndef ASCS_REGS_SVH
`define ASCS_REGS_SVH
// ---------------------------------------------------------------
// apb offsets
// ---------------------------------------------------------------
`define ASCS_OFF_STATUS 8'h00
`define ASCS_OFF_SPACE1 8'h04
`define ASCS_OFF_SPACE0 8'h08
`define ASCS_OFF_RSVD 8'h0c
`define ASCS_OFF_SPACE2 8'h10
`define ASCS_OFF_SPACE3 8'h14
// ---------------------------------------------------------------
// chip_space_timing_control fields
// ---------------------------------------------------------------
`define ASCS_WSU_MSB 31
`define ASCS_WSU_LSB 28
`define ASCS_WST_MSB 27
`define ASCS_WST_LSB 22
`define ASCS_WHD_MSB 21
`define ASCS_WHD_LSB 20
`define ASCS_RSU_MSB 19
`define ASCS_RSU_LSB 16
`define ASCS_TURN_MSB 15
`define ASCS_TURN_LSB 14
`define ASCS_RST_MSB 13
`define ASCS_RST_LSB 8
`define ASCS_KIND2_MSB 7
`define ASCS_KIND1_MSB 6
`define ASCS_KIND_LSB 4
`define ASCS_WHD2_BIT 3
`define ASCS_RHD2_MSB 2
`define ASCS_RHD1_MSB 1
`define ASCS_RHD_LSB 0
`define ASCS_CTL_RESET 32'hffff_ff23
`define ASCS_V1_RSV_MASK 32'h0000_c08c
`define ASCS_V1_RSV_VAL 32'h0000_c000
// ---------------------------------------------------------------
// memory kind codes and minimum counts
// ---------------------------------------------------------------
`define ASCS_KIND_ROM8 4'h0
`define ASCS_KIND_ROM16 4'h1
`define ASCS_KIND_ASYNC32 4'h2
`define ASCS_KIND_ASYNC8 4'h0
`define ASCS_KIND_ASYNC16 4'h1
`define ASCS_ROM_SPACE 2'h1
`define ASCS_MIN_PHASE 6'h01
`define ASCS_MIN_FIRST_SETUP 6'h02
`endif

// File: rtl/ascs_pkg.sv
// types shared by the async memory cycle shaper
package ascs_pkg;
  // access sequencer phases
  typedef enum logic [2:0] {ASCS_IDLE, ASCS_TURN, ASCS_SETUP, ASCS_STROBE, ASCS_HOLD} ascs_phase_e;
  // per-space control word array
  typedef logic [3:0][31:0] ascs_ctl_t;
endpackage

// File: rtl/ascs_sync2.sv
// two flip-flop synchroniser for the data pins
`timescale 1ns/1ps
module ascs_sync2 #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import ascs_pkg::*;
  // first stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ascs_sync_s;
  ascs_sync_s st;
  ascs_sync_s next_st;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// File: rtl/ascs_phase_cnt.sv
// loadable down counter that times one access phase
`timescale 1ns/1ps
module ascs_phase_cnt #(
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [CW-1:0] loadVal,
  output logic lastCycle
);
  import ascs_pkg::*;
  typedef struct packed {
    logic [CW-1:0] count;
  } ascs_cnt_s;
  ascs_cnt_s st;
  ascs_cnt_s next_st;

  // ---------------------------------------------------------------
  // reload at phase start, else count down to zero
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = loadVal;
    end else if (st.count != '0) begin
      next_st.count = st.count - CW'(1);
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // a phase of N cycles ends in the cycle where the count reads one
  assign lastCycle = (st.count <= CW'(1));
endmodule

// File: rtl/ascs_shaper.sv
// async memory cycle shaper: apb control words, access sequencer and memory pins
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ascs_regs.svh"
module ascs_shaper #(
  parameter int VARIANT = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [1:0] reqSpace,
  input wire logic [19:0] reqAddr,
  input wire logic [3:0] reqBe,
  input wire logic [31:0] reqWdata,
  output logic rdValid,
  output logic [31:0] rdData,
  output logic accErr,
  output logic [3:0] csN,
  output logic [19:0] extAddrOut,
  output logic [3:0] byteLaneSelN,
  output logic rdStrobeN,
  output logic wrStrobeN,
  output logic outEnableN,
  input wire logic [31:0] edIn,
  output logic [31:0] edOut,
  output logic edOeN
);
  import ascs_pkg::*;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (VARIANT != 1 && VARIANT != 2) begin : g_bad_variant
    $error("ascs_shaper: VARIANT must be 1 or 2");
  end

  // all state of the shaper
  typedef struct packed {
    ascs_phase_e phase;
    ascs_ctl_t ctl; // per-space timing control words
    logic [1:0] curSpace;
    logic curWrite;
    logic first; // first access to this space
    logic [5:0] setupN; // effective counts of the running access
    logic [5:0] strobeN;
    logic [5:0] holdN;
    logic [5:0] turnN;
    logic lastRead; // previous access was a read
    logic anyDone; // at least one access has completed
    logic [1:0] lastSpace;
    logic [3:0] csN;
    logic [19:0] extAddrOut;
    logic [3:0] byteLaneSelN;
    logic rdStrobeN;
    logic wrStrobeN;
    logic outEnableN;
    logic [31:0] edOut;
    logic edOeN;
    logic reqReady;
    logic rdValid;
    logic [31:0] rdData;
    logic accErr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] setupLen; // phase length meters, read by checks only
    logic [5:0] strobeLen;
    logic [5:0] turnLen;
  } ascs_state_s;
  ascs_state_s st;
  ascs_state_s next_st;

  logic [31:0] edSync; // data pins after synchroniser
  logic phaseLast; // counter says current phase ends now
  logic cntLoad;
  logic [5:0] cntVal;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] atLeast(input logic [5:0] v, input logic [5:0] m);
    return (v < m) ? m : v;
  endfunction
  // memory kind field; the second variant adds a bit
  function automatic logic [3:0] kindOf(input logic [31:0] c);
    if (VARIANT == 1) begin
      return {1'b0, c[`ASCS_KIND1_MSB:`ASCS_KIND_LSB]};
    end
    return c[`ASCS_KIND2_MSB:`ASCS_KIND_LSB];
  endfunction
  // hold counts; one bit wider on the second variant
  function automatic logic [5:0] holdOf(input logic [31:0] c, input logic wr);
    if (VARIANT == 1) begin
      return wr ? {4'h0, c[`ASCS_WHD_MSB:`ASCS_WHD_LSB]}
                : {4'h0, c[`ASCS_RHD1_MSB:`ASCS_RHD_LSB]};
    end
    return wr ? {3'h0, c[`ASCS_WHD2_BIT], c[`ASCS_WHD_MSB:`ASCS_WHD_LSB]}
              : {3'h0, c[`ASCS_RHD2_MSB:`ASCS_RHD_LSB]};
  endfunction
  // decide whether a space can run an async access of this direction
  function automatic logic usable(input logic [31:0] c, input logic [1:0] sp,
                                  input logic wr);
    logic [3:0] k;
    k = kindOf(c);
    if (VARIANT == 1) begin
      if (k == `ASCS_KIND_ASYNC32) begin
        return 1'b1;
      end
      // roms are read-only and only live in space one
      return (k == `ASCS_KIND_ROM8 || k == `ASCS_KIND_ROM16) && !wr &&
             sp == `ASCS_ROM_SPACE;
    end
    return k == `ASCS_KIND_ASYNC8 || k == `ASCS_KIND_ASYNC16 || k == `ASCS_KIND_ASYNC32;
  endfunction

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  ascs_sync2 #(.W(32)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(edIn),
    .q(edSync)
  );
  // all intervals are counted on clk, whichever variant
  ascs_phase_cnt #(.CW(6)) uCnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(cntLoad),
    .loadVal(cntVal),
    .lastCycle(phaseLast)
  );
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    logic goSetup;
    logic finish;
    logic take;
    logic [7:0] idx;
    logic [31:0] w;
    c = st.ctl[reqSpace];
    goSetup = 1'b0;
    finish = 1'b0;
    take = 1'b0;
    idx = paddr;
    // reserved bits of the first variant keep their fixed values
    w = (VARIANT == 1) ? ((pwdata & ~`ASCS_V1_RSV_MASK) | `ASCS_V1_RSV_VAL) : pwdata;
    next_st = st;
    cntLoad = 1'b0;
    cntVal = '0;
    next_st.rdValid = 1'b0;
    next_st.accErr = 1'b0;
    // apb slave: one wait cycle, effect at the edge with pready high
    next_st.pready = psel && penable && !st.pready;
    if (psel && penable && !st.pready) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      case (idx)
        `ASCS_OFF_STATUS: next_st.prdata = {26'h0, st.lastSpace, st.lastRead, st.anyDone,
                                            st.first, st.phase != ASCS_IDLE};
        `ASCS_OFF_SPACE0: next_st.prdata = st.ctl[0];
        `ASCS_OFF_SPACE1: next_st.prdata = st.ctl[1];
        `ASCS_OFF_SPACE2: next_st.prdata = st.ctl[2];
        `ASCS_OFF_SPACE3: next_st.prdata = st.ctl[3];
        `ASCS_OFF_RSVD: next_st.prdata = '0;
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && st.pready && pwrite) begin
      case (idx)
        `ASCS_OFF_SPACE0: next_st.ctl[0] = w;
        `ASCS_OFF_SPACE1: next_st.ctl[1] = w;
        `ASCS_OFF_SPACE2: next_st.ctl[2] = w;
        `ASCS_OFF_SPACE3: next_st.ctl[3] = w;
        default: ;
      endcase
    end
    // phase meters for checks
    next_st.setupLen = (st.phase == ASCS_SETUP) ? st.setupLen + 6'h01 : '0;
    next_st.strobeLen = (st.phase == ASCS_STROBE) ? st.strobeLen + 6'h01 : '0;
    next_st.turnLen = (st.phase == ASCS_TURN) ? st.turnLen + 6'h01 : '0;
    unique case (st.phase)
      ASCS_IDLE: begin
        // a kept select is dropped when no same-space access follows
        if (!(reqValid && reqSpace == st.curSpace)) begin
          next_st.csN = 4'hf;
        end
        if (reqValid && st.reqReady) begin
          take = 1'b1;
          next_st.reqReady = 1'b0;
          next_st.curSpace = reqSpace;
          next_st.curWrite = reqWrite;
          next_st.first = st.csN[reqSpace];
          // separate timing sets per direction, zero setup or strobe treated as one
          next_st.setupN = atLeast(reqWrite ? {2'h0, c[`ASCS_WSU_MSB:`ASCS_WSU_LSB]}
                                            : {2'h0, c[`ASCS_RSU_MSB:`ASCS_RSU_LSB]},
                                   `ASCS_MIN_PHASE);
          if (VARIANT == 1 && st.csN[reqSpace]) begin
            next_st.setupN = atLeast(next_st.setupN, `ASCS_MIN_FIRST_SETUP);
          end
          next_st.strobeN = atLeast(reqWrite ? c[`ASCS_WST_MSB:`ASCS_WST_LSB]
                                             : c[`ASCS_RST_MSB:`ASCS_RST_LSB],
                                    `ASCS_MIN_PHASE);
          next_st.holdN = holdOf(c, reqWrite);
          next_st.turnN = {4'h0, c[`ASCS_TURN_MSB:`ASCS_TURN_LSB]};
          next_st.extAddrOut = reqAddr;
          next_st.byteLaneSelN = ~reqBe;
          next_st.edOut = reqWdata;
          if (!usable(c, reqSpace, reqWrite)) begin
            // timing fields ignored, access refused with no select or strobe; address and lanes still load
            next_st.accErr = 1'b1;
            next_st.reqReady = 1'b1;
          end else if (VARIANT == 2 && st.anyDone && st.lastRead &&
                       (reqWrite || reqSpace != st.lastSpace) &&
                       c[`ASCS_TURN_MSB:`ASCS_TURN_LSB] != 2'h0) begin
            next_st.phase = ASCS_TURN;
            next_st.csN = 4'hf;
            next_st.first = 1'b1;
            cntLoad = 1'b1;
            cntVal = {4'h0, c[`ASCS_TURN_MSB:`ASCS_TURN_LSB]};
          end else begin
            goSetup = 1'b1;
          end
        end
      end
      ASCS_TURN: begin
        // bus idles for the turnaround count
        if (phaseLast) begin
          goSetup = 1'b1;
        end
      end
      ASCS_SETUP: begin
        if (phaseLast) begin
          next_st.phase = ASCS_STROBE;
          next_st.wrStrobeN = !st.curWrite;
          next_st.rdStrobeN = st.curWrite;
          cntLoad = 1'b1;
          cntVal = st.strobeN;
        end
      end
      ASCS_STROBE: begin
        if (phaseLast) begin
          next_st.wrStrobeN = 1'b1;
          next_st.rdStrobeN = 1'b1;
          if (!st.curWrite) begin
            next_st.rdData = edSync;
            next_st.rdValid = 1'b1;
          end
          if (st.holdN == '0) begin
            finish = 1'b1;
          end else begin
            next_st.phase = ASCS_HOLD;
            cntLoad = 1'b1;
            cntVal = st.holdN;
          end
        end
      end
      ASCS_HOLD: begin
        // address and lanes untouched here
        if (phaseLast) begin
          finish = 1'b1;
        end
      end
    endcase
    if (goSetup) begin
      // select low with address valid opens the cycle
      next_st.phase = ASCS_SETUP;
      next_st.csN = 4'hf;
      next_st.csN[next_st.curSpace] = 1'b0;
      next_st.outEnableN = next_st.curWrite;
      next_st.edOeN = !next_st.curWrite;
      cntLoad = 1'b1;
      cntVal = next_st.setupN;
    end
    if (finish) begin
      next_st.phase = ASCS_IDLE;
      next_st.reqReady = 1'b1;
      next_st.lastRead = !st.curWrite;
      next_st.lastSpace = st.curSpace;
      next_st.anyDone = 1'b1;
      next_st.outEnableN = 1'b1;
      next_st.edOeN = 1'b1;
      // keep select only if a same-space access waits
      if (!(reqValid && reqSpace == st.curSpace)) begin
        next_st.csN = 4'hf;
      end
    end
    if (take && next_st.accErr) begin // a refused access keeps the previous write data on the pins
      next_st.edOut = st.edOut;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= ASCS_IDLE;
      st.ctl <= {4{`ASCS_CTL_RESET}};
      st.csN <= 4'hf;
      st.byteLaneSelN <= 4'hf;
      st.rdStrobeN <= 1'b1;
      st.wrStrobeN <= 1'b1;
      st.outEnableN <= 1'b1;
      st.edOeN <= 1'b1;
      st.reqReady <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign reqReady = st.reqReady;
  assign rdValid = st.rdValid;
  assign rdData = st.rdData;
  assign accErr = st.accErr;
  assign csN = st.csN;
  assign extAddrOut = st.extAddrOut;
  assign byteLaneSelN = st.byteLaneSelN;
  assign rdStrobeN = st.rdStrobeN;
  assign wrStrobeN = st.wrStrobeN;
  assign outEnableN = st.outEnableN;
  assign edOut = st.edOut;
  assign edOeN = st.edOeN;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_setup_length: assert property ($fell(st.rdStrobeN) || $fell(st.wrStrobeN) |->
    st.setupLen == st.setupN) else $error("setup length wrong");
  a_strobe_width: assert property ($rose(st.rdStrobeN) || $rose(st.wrStrobeN) |->
    st.strobeLen == st.strobeN) else $error("strobe width wrong");
  a_hold_stable: assert property (st.phase == ASCS_HOLD |->
    $stable(st.extAddrOut) && $stable(st.byteLaneSelN)) else $error("address moved in hold");
  a_first_setup: assert property ($fell(st.rdStrobeN & st.wrStrobeN) && st.first |->
    VARIANT != 1 || st.setupLen >= 6'h02) else $error("first setup under two");
  a_read_oe: assert property (st.phase != ASCS_IDLE && st.phase != ASCS_TURN && !st.curWrite |->
    !st.outEnableN) else $error("output enable high in read");
  a_read_capture: assert property ($rose(st.rdStrobeN) |-> st.rdValid &&
    st.rdData == $past(edSync)) else $error("read data not captured");
  a_turn_length: assert property ($past(st.phase) == ASCS_TURN && st.phase == ASCS_SETUP |->
    st.turnLen == st.turnN && VARIANT == 2) else $error("turnaround length wrong");
  a_zero_hold: assert property ($rose(st.rdStrobeN) && st.holdN == '0 |->
    st.phase == ASCS_IDLE && st.reqReady) else $error("zero hold not ended");
  a_select_start: assert property (st.phase == ASCS_SETUP |->
    !st.csN[st.curSpace]) else $error("select high in setup");
  c_read_done: cover property ($rose(st.rdStrobeN) && st.rdValid);
  c_write_done: cover property ($rose(st.wrStrobeN) ##[1:63] st.reqReady);
  c_turnaround: cover property (st.phase == ASCS_TURN ##1 st.phase == ASCS_SETUP);
  c_kept_select: cover property (st.phase == ASCS_SETUP && !st.first);
endmodule

// File: verif/ascs_sram_model.sv
// asynchronous static ram model on the memory pins of the cycle shaper
`timescale 1ns/1ps
module ascs_sram_model (
  input wire logic clk,
  input wire logic csN,
  input wire logic [19:0] extAddrOut,
  input wire logic [3:0] byteLaneSelN,
  input wire logic wrStrobeN,
  input wire logic outEnableN,
  input wire logic [31:0] edOut,
  input wire logic edOeN,
  output logic [31:0] edIn
);
  logic [31:0] mem [16]; // small array, address wraps every 16 words
  logic [31:0] last = 32'h0; // last driven level
  // ------
  // data wire level
  // ------
  // a floating wire shows the inverse of the last level, so stale data never passes
  always_comb begin
    if (edOeN === 1'h0) begin
      edIn = edOut;
    end else if (csN === 1'h0 && outEnableN === 1'h0) begin
      edIn = mem[extAddrOut[3:0]];
    end else begin
      edIn = ~last;
    end
  end
  // writes land lane by lane during every strobe cycle; the last one wins
  always @(posedge clk) begin
    if (csN === 1'h0 && wrStrobeN === 1'h0) begin
      for (int i = 0; i < 4; i++) begin
        if (byteLaneSelN[i] === 1'h0) begin
          mem[extAddrOut[3:0]][i*8 +: 8] <= edIn[i*8 +: 8];
        end
      end
    end
    if (edOeN === 1'h0 || (csN === 1'h0 && outEnableN === 1'h0)) begin
      last <= edIn;
    end
  end
endmodule

// File: verif/tb_async_memory_cycle_shaper.sv
// self-checking bench of the async memory cycle shaper with a static ram model
`timescale 1ns/1ps
`include "ascs_regs.svh"
module tb_async_memory_cycle_shaper;
  logic clk = 1'h0;
  logic rst = 1'h1; // synchronous, active high
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic reqValid = 1'h0;
  logic reqWrite = 1'h0;
  logic [1:0] reqSpace = 2'h0;
  logic [19:0] reqAddr = 20'h0;
  logic [3:0] reqBe = 4'hf; // full words only: partial lanes would read unwritten bytes
  logic [31:0] reqWdata = 32'h0;
  logic [31:0] prdata, rdData, edIn, edOut;
  logic pready, pslverr, reqReady, rdValid, accErr, rdStrobeN, wrStrobeN, outEnableN, edOeN;
  logic [19:0] extAddrOut;
  logic [3:0] csN, byteLaneSelN;
  int miscompares = 0;
  int checkCount = 0;
  always #12.5 clk = ~clk;
  ascs_shaper #(.VARIANT(1)) dut (
    .clk(clk), .sys_rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqSpace(reqSpace),
    .reqAddr(reqAddr), .reqBe(reqBe), .reqWdata(reqWdata), .rdValid(rdValid),
    .rdData(rdData), .accErr(accErr), .csN(csN), .extAddrOut(extAddrOut),
    .byteLaneSelN(byteLaneSelN), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN),
    .outEnableN(outEnableN), .edIn(edIn), .edOut(edOut), .edOeN(edOeN)
  );
  // only space 0 has a memory behind it
  ascs_sram_model mem0 (
    .clk(clk), .csN(csN[0]), .extAddrOut(extAddrOut), .byteLaneSelN(byteLaneSelN),
    .wrStrobeN(wrStrobeN), .outEnableN(outEnableN), .edOut(edOut), .edOeN(edOeN),
    .edIn(edIn)
  );
  // ------
  // helpers
  // ------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int atl(input int v, input int m);
    return (v > m) ? v : m;
  endfunction
  // control word with reserved bits at their read values
  function automatic logic [31:0] ctl(input int rs, rt, rh, ws, wt, wh, k);
    return {ws[3:0], wt[5:0], wh[1:0], rs[3:0], 2'h3, rt[5:0], 1'h0, k[2:0], 2'h0, rh[1:0]};
  endfunction
  // apb transfer: held until pready is seen, data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) chk(64'h1, 64'h0);
  endtask
  task automatic prog(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] rd;
    logic err;
    apb(1'h1, a, v, rd, err);
    apb(1'h0, a, 32'h0, rd, err);
    chk(64'({err, rd}), 64'({1'h0, v}));
  endtask
  // request held until taken
  task automatic issue(input logic w, input logic [1:0] sp, input logic [19:0] a,
                       input logic [31:0] d);
    @(posedge clk);
    reqValid <= 1'h1;
    reqWrite <= w;
    reqSpace <= sp;
    reqAddr <= a;
    reqWdata <= d;
    @(negedge clk);
    while (reqReady !== 1'h1) @(negedge clk);
    @(posedge clk);
    reqValid <= 1'h0;
  endtask
  // one access, phases measured on the pins each cycle
  task automatic acc(input logic w, input logic [1:0] sp, input logic [19:0] a,
                     input logic [31:0] d, input int s, input int t, input int h);
    int cs, ct, ch, n;
    logic post, stb;
    cs = 0;
    ct = 0;
    ch = 0;
    post = 1'h0;
    issue(w, sp, a, d);
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      stb = w ? wrStrobeN : rdStrobeN;
      if (stb === 1'h0) begin
        ct++;
      end else if (ct == 0) begin
        cs += int'(csN[sp] === 1'h0);
      end else begin
        if (!post && !w) chk(64'({rdValid, rdData}), 64'({1'h1, d}));
        post = 1'h1;
        if (reqReady === 1'h1) break;
        ch++;
      end
      chk(64'({csN[sp], outEnableN, extAddrOut, byteLaneSelN}), 64'({1'h0, w, a, 4'h0}));
      chk(64'({edOeN, (w ? rdStrobeN : wrStrobeN)}), 64'({!w, 1'h1}));
    end
    chk(64'(cs), 64'(s));
    chk(64'(ct), 64'(t));
    chk(64'(ch), 64'(h));
    chk(64'(csN[sp]), 64'h1);
  endtask
  // ------
  // scenarios
  // ------
  task automatic test_regs;
    logic [31:0] rd;
    logic err;
    apb(1'h0, `ASCS_OFF_SPACE3, 32'h0, rd, err);
    chk(64'({err, rd}), 64'({1'h0, `ASCS_CTL_RESET}));
    apb(1'h1, `ASCS_OFF_RSVD, 32'hffff_ffff, rd, err);
    apb(1'h0, `ASCS_OFF_RSVD, 32'h0, rd, err);
    chk(64'({err, rd}), 64'h0);
    apb(1'h0, 8'h40, 32'h0, rd, err);
    chk(64'(err), 64'h1);
    apb(1'h1, `ASCS_OFF_SPACE2, 32'h0, rd, err);
    apb(1'h0, `ASCS_OFF_SPACE2, 32'h0, rd, err);
    chk(64'(rd), 64'(`ASCS_V1_RSV_VAL));
    $display("register test done");
  endtask
  // write then read one word, both as first accesses of space 0
  task automatic timing(input int rs, rt, rh, ws, wt, wh);
    logic [19:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic err;
    a = 20'(rs * 7 + rt);
    d = 32'h5a3c_0000 ^ 32'(a);
    prog(`ASCS_OFF_SPACE0, ctl(rs, rt, rh, ws, wt, wh, 2));
    acc(1'h1, 2'h0, a, d, atl(ws, 2), atl(wt, 1), wh);
    acc(1'h0, 2'h0, a, d, atl(rs, 2), atl(rt, 1), rh);
    // status: space 0, last was a read, one done, first access, idle
    apb(1'h0, `ASCS_OFF_STATUS, 32'h0, rd, err);
    chk(64'({err, rd}), 64'h0e);
    $display("timing test %0d/%0d/%0d done", rs, rt, rh);
  endtask
  // a refused access leaves every select and both strobes idle
  task automatic refused(input logic w, input logic [1:0] sp);
    logic seen;
    seen = 1'h0;
    issue(w, sp, 20'h0, 32'h0);
    repeat (4) begin
      @(negedge clk);
      seen = seen | (accErr === 1'h1);
      chk(64'({csN, rdStrobeN, wrStrobeN}), 64'h3f);
    end
    chk(64'(seen), 64'h1);
  endtask
  task automatic test_refuse;
    for (int k = 0; k < 8; k++) begin
      if (k != 2) begin
        prog(`ASCS_OFF_SPACE0, ctl(1, 1, 0, 1, 1, 0, k));
        refused(1'h0, 2'h0);
      end
    end
    prog(`ASCS_OFF_SPACE1, ctl(1, 1, 0, 1, 1, 0, 1));
    refused(1'h1, 2'h1);
    $display("refusal test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------
  // main sequence and watchdog
  // ------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    test_regs();
    timing(3, 2, 1, 1, 3, 2);
    timing(0, 0, 0, 0, 0, 0);
    timing(1, 1, 3, 4, 1, 0);
    timing(15, 63, 3, 15, 63, 3);
    test_refuse();
    results();
  end
  // the whole run needs under a thousand cycles; twenty thousand means a hang
  initial begin
    #500000;
    miscompares++;
    results();
  end
endmodule
